// file: design/agc_status_page_dither_regs.sv
`timescale 1ns/100ps
module agc_status_page_dither_regs
(
  input  wire logic       i_core_clk,
  input  wire logic       i_resetn,
  input  wire logic       i_reg_wr,
  input  wire logic       i_reg_rd,
  input  wire logic [6:0] i_reg_addr,
  input  wire logic [7:0] i_reg_wdata,
  output logic      [7:0] o_reg_rdata,
  output logic            o_reg_rvalid,
  input  wire logic       i_sample_tick,
  input  wire logic       i_agc_signal_raw,
  input  wire logic       i_agc_gain_update,
  input  wire logic [7:0] i_agc_gain,
  output logic            o_agc_signal_qualified,
  output logic      [7:0] o_page,
  output logic      [3:0] o_left_dc_offset,
  output logic      [3:0] o_right_dc_offset
);
  logic [7:0] page_r;
  logic [7:0] page_nxt;
  logic [7:0] dither_r;
  logic [7:0] dither_nxt;
  logic [3:0] debounce_r;
  logic [3:0] debounce_nxt;
  logic [7:0] gain_r;
  logic [7:0] gain_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic       rvalid_r;
  logic       rvalid_nxt;
  logic       on_page0;
  logic       on_page1;
  logic       sel_page;
  logic       sel_debounce;
  logic       sel_gain;
  logic       sel_dither;
  logic       rsvd_page0;
  logic       rsvd_page1_low;
  logic       rsvd_page1_high;
  logic       rsvd_hit;
  logic       wr_page;
  logic       wr_debounce;
  logic       wr_dither;
  logic       gain_above;
  logic       gain_below;
  logic [7:0] gain_clamped;
  logic [3:0] offset_view [2];

  assign o_page       = page_r;
  assign o_reg_rdata  = rdata_r;
  assign o_reg_rvalid = rvalid_r;

  // Offset channel 0 feeds the right converter input, channel 1 the left
  for (genvar ch = 0; ch < 2; ch++)
  begin : g_offset_view
    localparam int LSB = (ch == 0) ? agc_regs_pkg::RIGHT_OFFSET_LSB
                                   : agc_regs_pkg::LEFT_OFFSET_LSB;
    assign offset_view[ch] = dither_r[LSB +: 4];
  end
  assign o_left_dc_offset  = offset_view[1];
  assign o_right_dc_offset = offset_view[0];

  // Page select sits at location 0 of every page, so the host can always leave a page
  assign on_page0     = (page_r == agc_regs_pkg::PAGE_ZERO);
  assign on_page1     = (page_r == agc_regs_pkg::PAGE_ONE);
  assign sel_page     = (i_reg_addr == agc_regs_pkg::PAGE_SELECT_OFS);
  assign sel_debounce = on_page0 && (i_reg_addr == agc_regs_pkg::DEBOUNCE_OFS);
  assign sel_gain     = on_page0 && (i_reg_addr == agc_regs_pkg::GAIN_STATUS_OFS);
  assign sel_dither   = on_page1 && (i_reg_addr == agc_regs_pkg::DITHER_OFS);

  // Reserved ranges hold no storage; the page 0 range runs to the top of the space
  assign rsvd_page0      = on_page0
                           && (i_reg_addr >= agc_regs_pkg::PAGE0_RSVD_FIRST);
  assign rsvd_page1_low  = on_page1
                           && (i_reg_addr >= agc_regs_pkg::PAGE1_RSVD_LOW_FIRST)
                           && (i_reg_addr <= agc_regs_pkg::PAGE1_RSVD_LOW_LAST);
  assign rsvd_page1_high = on_page1
                           && (i_reg_addr >= agc_regs_pkg::PAGE1_RSVD_HIGH_FIRST)
                           && (i_reg_addr <= agc_regs_pkg::PAGE1_RSVD_HIGH_LAST);
  assign rsvd_hit        = rsvd_page0 || rsvd_page1_low || rsvd_page1_high;

  // A write into a reserved range is dropped
  assign wr_page     = i_reg_wr && sel_page;
  assign wr_debounce = i_reg_wr && sel_debounce && !rsvd_hit;
  assign wr_dither   = i_reg_wr && sel_dither && !rsvd_hit;

  signal_debounce u_signal_debounce
  (
    .i_core_clk    (i_core_clk),
    .i_resetn      (i_resetn),
    .i_sample_tick (i_sample_tick),
    .i_code        (debounce_r),
    .i_raw         (i_agc_signal_raw),
    .o_qualified   (o_agc_signal_qualified)
  );

  // Saturate rather than wrap, so a reserved gain code never reaches the status register
  assign gain_above = !i_agc_gain[7] && (i_agc_gain > agc_regs_pkg::GAIN_MAX_CODE);
  assign gain_below = i_agc_gain[7] && (i_agc_gain < agc_regs_pkg::GAIN_MIN_CODE);

  always_comb
  begin
    gain_clamped = i_agc_gain;
    if (gain_above)
      gain_clamped = agc_regs_pkg::GAIN_MAX_CODE;
    else if (gain_below)
      gain_clamped = agc_regs_pkg::GAIN_MIN_CODE;
    // Only the gain engine updates this register; host writes never reach it
    gain_nxt = gain_r;
    if (i_agc_gain_update)
      gain_nxt = gain_clamped;
  end

  always_ff @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      gain_r <= agc_regs_pkg::GAIN_STATUS_RST;
    end
    else
    begin
      gain_r <= gain_nxt;
    end
  end

  always_comb
  begin
    page_nxt = page_r;
    // Any value is stored; keeping to valid pages is left to the host
    if (wr_page)
      page_nxt = i_reg_wdata;
  end

  always_ff @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      page_r <= agc_regs_pkg::PAGE_SELECT_RST;
    end
    else
    begin
      page_r <= page_nxt;
    end
  end

  always_comb
  begin
    debounce_nxt = debounce_r;
    // Only the code field is stored, so the reserved top bits always read zero
    if (wr_debounce)
      debounce_nxt = i_reg_wdata[agc_regs_pkg::DEBOUNCE_FIELD_LSB +: 4];
  end

  always_ff @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      debounce_r <= agc_regs_pkg::DEBOUNCE_RST;
    end
    else
    begin
      debounce_r <= debounce_nxt;
    end
  end

  always_comb
  begin
    dither_nxt = dither_r;
    // Both offset fields change together in one write
    if (wr_dither)
      dither_nxt = i_reg_wdata;
  end

  always_ff @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      dither_r <= agc_regs_pkg::DITHER_RST;
    end
    else
    begin
      dither_r <= dither_nxt;
    end
  end

  always_comb
  begin
    // A read in the same cycle as a write returns the value from before the write
    rvalid_nxt = i_reg_rd;
    rdata_nxt  = agc_regs_pkg::RESERVED_READ;
    if (i_reg_rd)
    begin
      if (sel_page)
        rdata_nxt = page_r;
      else if (sel_debounce)
        rdata_nxt = {4'h0, debounce_r};
      else if (sel_gain)
        rdata_nxt = gain_r;
      else if (sel_dither)
        rdata_nxt = dither_r;
      else if (rsvd_hit)
        rdata_nxt = agc_regs_pkg::RESERVED_READ;
      else
        rdata_nxt = agc_regs_pkg::RESERVED_READ;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      rdata_r  <= agc_regs_pkg::RESERVED_READ;
      rvalid_r <= 1'b0;
    end
    else
    begin
      rdata_r  <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end
endmodule : agc_status_page_dither_regs

// file: design/agc_regs_pkg.sv
package agc_regs_pkg;
  localparam logic [6:0] PAGE_SELECT_OFS    = 7'h00;
  localparam logic [6:0] DITHER_OFS         = 7'h1a;
  localparam logic [6:0] DEBOUNCE_OFS       = 7'h64;
  localparam logic [6:0] GAIN_STATUS_OFS    = 7'h65;
  localparam logic [7:0] PAGE_ZERO          = 8'h00;
  localparam logic [7:0] PAGE_ONE           = 8'h01;
  localparam logic [7:0] PAGE_SELECT_RST    = 8'h00;
  localparam logic [7:0] DITHER_RST         = 8'h00;
  localparam logic [3:0] DEBOUNCE_RST       = 4'h0;
  localparam logic [7:0] GAIN_STATUS_RST    = 8'h00;
  localparam logic [7:0] GAIN_MAX_CODE      = 8'h50;
  localparam logic [7:0] GAIN_MIN_CODE      = 8'he8;
  localparam logic [7:0] RESERVED_READ      = 8'h00;
  localparam logic [6:0] PAGE0_RSVD_FIRST      = 7'h66;
  localparam logic [6:0] PAGE1_RSVD_LOW_FIRST  = 7'h01;
  localparam logic [6:0] PAGE1_RSVD_LOW_LAST   = 7'h19;
  localparam logic [6:0] PAGE1_RSVD_HIGH_FIRST = 7'h1b;
  localparam logic [6:0] PAGE1_RSVD_HIGH_LAST  = 7'h32;
  localparam int         DEBOUNCE_CNT_W     = 17;
  localparam int         DEBOUNCE_FIELD_LSB = 0;
  localparam int         LEFT_OFFSET_LSB    = 4;
  localparam int         RIGHT_OFFSET_LSB   = 0;
endpackage : agc_regs_pkg

// file: design/signal_debounce.sv
`timescale 1ns/100ps
module signal_debounce
(
  input  wire logic       i_core_clk,
  input  wire logic       i_resetn,
  input  wire logic       i_sample_tick,
  input  wire logic [3:0] i_code,
  input  wire logic       i_raw,
  output logic            o_qualified
);
  localparam int CW = agc_regs_pkg::DEBOUNCE_CNT_W;

  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic [CW-1:0] limit;
  logic          qual_r;
  logic          qual_nxt;

  assign o_qualified = qual_r;

  always_comb
  begin
    // Code 0 means no debounce, code n waits 4 << (n-1) sample periods
    if (i_code == 4'h0)
      limit = '0;
    else
      limit = CW'(17'h00004 << (i_code - 4'h1));
    cnt_nxt  = cnt_r;
    qual_nxt = qual_r;
    if (i_raw == qual_r)
      cnt_nxt = '0;
    else if (cnt_r >= limit)
    begin
      qual_nxt = i_raw;
      cnt_nxt  = '0;
    end
    else if (i_sample_tick)
      cnt_nxt = cnt_r + CW'(1);
  end

  always_ff @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      cnt_r  <= '0;
      qual_r <= 1'b0;
    end
    else
    begin
      cnt_r  <= cnt_nxt;
      qual_r <= qual_nxt;
    end
  end
endmodule : signal_debounce

// file: verification/agc_regs_chk.sv
`timescale 1ns/100ps
module agc_regs_chk
(
  input wire logic       i_core_clk,
  input wire logic       i_resetn,
  input wire logic       i_reg_wr,
  input wire logic       i_reg_rd,
  input wire logic [6:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic [7:0] o_reg_rdata,
  input wire logic       o_reg_rvalid,
  input wire logic [7:0] o_page,
  input wire logic [3:0] o_left_dc_offset,
  input wire logic [3:0] o_right_dc_offset
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);
  wire logic dw = i_reg_wr && i_reg_addr == 7'h1a && o_page == 8'h01;
  wire logic pw = i_reg_wr && i_reg_addr == 7'h00;
  read_answer_a: assert property (i_reg_rd |=> o_reg_rvalid) else $error("no rvalid");
  idle_data_a: assert property (!o_reg_rvalid |-> !o_reg_rdata) else $error("idle data");
  gain_legal_a: assert property (o_reg_rvalid && $past(i_reg_addr) == 7'h65 &&
    !$past(o_page) |-> $signed(o_reg_rdata) >= -24 && $signed(o_reg_rdata) <= 80) else $error("gain");
  page_set_a: assert property (pw |=> o_page == $past(i_reg_wdata)) else $error("page set");
  page_hold_a: assert property (!pw |=> $stable(o_page)) else $error("page moved");
  dither_set_a: assert property (dw |=> {o_left_dc_offset, o_right_dc_offset} ==
    $past(i_reg_wdata)) else $error("dither set");
  dither_hold_a: assert property (!dw |=> $stable({o_left_dc_offset, o_right_dc_offset}))
    else $error("dither moved");
  debounce_top_a: assert property (o_reg_rvalid && $past(i_reg_addr) == 7'h64
    |-> o_reg_rdata[7:4] == 4'h0) else $error("debounce top bits");
endmodule : agc_regs_chk
bind agc_status_page_dither_regs agc_regs_chk chk (.*);

// file: verification/agc_status_page_dither_regs_tb_top.sv
`timescale 1ns/100ps
module agc_status_page_dither_regs_tb_top;
  logic       clk = 0, rstn = 0, wr = 0, rd = 0, tick = 0, raw = 0, upd = 0, rvalid, qual;
  logic [6:0] addr = 7'h00;
  logic [7:0] wd = 8'h00, gain = 8'h00, rdata, page, v;
  logic [7:0] cg[6] = '{8'h50, 8'h51, 8'he8, 8'he7, 8'h7f, 8'h80};
  logic [3:0] lo, ro;
  int         error_cnt = 0, tests_run = 0, k, b;
  agc_status_page_dither_regs uut (.i_core_clk(clk), .i_resetn(rstn), .i_reg_wr(wr),
    .i_reg_rd(rd), .i_reg_addr(addr), .i_reg_wdata(wd), .o_reg_rdata(rdata),
    .o_reg_rvalid(rvalid), .i_sample_tick(tick), .i_agc_signal_raw(raw),
    .i_agc_gain_update(upd), .i_agc_gain(gain), .o_agc_signal_qualified(qual),
    .o_page(page), .o_left_dc_offset(lo), .o_right_dc_offset(ro));
  initial forever #2.5 clk = ~clk;
  task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e)
    begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask : cmp
  task automatic stop_test;
    $display("errors %0d checks %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : stop_test
  task automatic wreg(input logic [6:0] a, input logic [7:0] d);
    @(negedge clk) {wr, addr, wd} = {1'b1, a, d};
    @(negedge clk) wr = 0;
  endtask : wreg
  task automatic rreg(input logic [6:0] a, input logic [7:0] e);
    @(negedge clk) {rd, addr} = {1'b1, a};
    @(negedge clk) rd = 0;
    cmp("rvalid", 8'h01, {7'h00, rvalid});
    cmp("rdata", e, rdata);
  endtask : rreg
  // Out-of-range gain requests saturate instead of showing reserved codes
  function automatic logic [7:0] clamp(input logic [7:0] g);
    return $signed(g) > 80 ? 8'h50 : $signed(g) < -24 ? 8'he8 : g;
  endfunction : clamp
  initial
  begin
    #100000;
    error_cnt++;
    stop_test;
  end
  initial
  begin
    v = 8'($urandom(32'heba2c47e));
    repeat (5) @(negedge clk);
    rstn = 1;
    rreg(7'h00, 8'h00);
    rreg(7'h64, 8'h00);
    wreg(7'h65, 8'hff);
    rreg(7'h65, 8'h00);
    wreg(7'h64, 8'h0f);
    rreg(7'h64, 8'h0f);
    for (int i = 0; i < 20; i++)
    begin
      v = i < 6 ? cg[i] : 8'($urandom);
      @(negedge clk) {upd, gain} = {1'b1, v};
      @(negedge clk) upd = 0;
      rreg(7'h66 + 7'(i), 8'h00);
      rreg(7'h65, clamp(v));
    end
    rreg(7'h64, 8'h0f);
    tick = 1;
    for (int n = 0; n < 5; n++)
    begin
      b = n ? 2 ** (n + 1) : 0;
      wreg(7'h64, 8'(n));
      @(negedge clk) raw = 1;
      for (k = 0; k < 99 && qual !== 1'b1; k++) @(negedge clk);
      cmp("delay", 8'h01, {7'h00, k >= b && k <= b + 3});
      raw = 0;
      repeat (40) @(negedge clk);
    end
    wreg(7'h00, 8'h01);
    cmp("page", 8'h01, page);
    rreg(7'h1a, 8'h00);
    v = 8'($urandom);
    wreg(7'h1a, v);
    rreg(7'h19, 8'h00);
    rreg(7'h1b, 8'h00);
    cmp("offsets", v, {lo, ro});
    rreg(7'h1a, v);
    stop_test;
  end
endmodule : agc_status_page_dither_regs_tb_top
